// *** rtl/tcc_pkg.sv ***
// package for the 16-bit timer/counter with input capture
package tcc_pkg;

    // ------------------------------------------------------------
    // register locations on the 8-bit data bus
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL_A      = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B      = 4'h1;
    localparam logic [3:0] ADDR_COUNT_LO    = 4'h2;
    localparam logic [3:0] ADDR_COUNT_HI    = 4'h3;
    localparam logic [3:0] ADDR_CAPT_LO     = 4'h4;
    localparam logic [3:0] ADDR_CAPT_HI     = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK    = 4'h6;
    localparam logic [3:0] ADDR_IRQ_FLAG    = 4'h7;
    localparam logic [3:0] ADDR_CMP_CTRL    = 4'h8;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_OVF          = 0;  // flag / mask: overflow
    localparam int BIT_CAPT         = 5;  // flag / mask: capture
    localparam int BIT_EDGE         = 6;  // control b: rising edge select
    localparam int BIT_FILT         = 7;  // control b: noise filter enable
    localparam int BIT_CMP_SEL      = 2;  // comparator control: capture source

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam logic [15:0] COUNT_ZERO  = 16'h0000;
    localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE   = 16'h0001;
    localparam logic [2:0]  CS_STOPPED  = 3'h0;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    localparam int          FILT_SAMPLES = 4;
    localparam logic [2:0]  FILT_LAST   = 3'h3;  // samples after the first

    // waveform modes whose ceiling is the capture register
    localparam logic [3:0] WGM_PWM_ICR   = 4'h8;
    localparam logic [3:0] WGM_PWM_ICR_F = 4'hA;
    localparam logic [3:0] WGM_CTC_ICR   = 4'hC;
    localparam logic [3:0] WGM_FAST_ICR  = 4'hE;
    // dual-slope modes (count up then down)
    localparam logic [3:0] WGM_PC8       = 4'h1;
    localparam logic [3:0] WGM_PC9       = 4'h2;
    localparam logic [3:0] WGM_PC10      = 4'h3;
    localparam logic [3:0] WGM_PFC_OCR   = 4'h9;
    localparam logic [3:0] WGM_PC_OCR    = 4'hB;

    // processor bus access
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } tcc_bus_t;

    typedef enum logic {DIR_UP, DIR_DOWN} tcc_dir_t;

endpackage

// *** rtl/tcc_timer16.sv ***
// 16-bit timer/counter with byte access and input capture
`timescale 1ns/1ps
module tcc_timer16 (
    input  wire logic             clk,            // system clock, 10 MHz
    input  wire logic             arst_n,         // asynchronous reset, active low
    input  wire tcc_pkg::tcc_bus_t bus,           // processor access strobes
    output logic [7:0]            rdata,          // read data, registered
    input  wire logic             timer_tick,     // one-cycle tick from clock select logic
    input  wire logic [15:0]      ceiling_ocr,    // ceiling from compare unit a
    input  wire logic             capture_input_pin, // capture pin, asynchronous
    input  wire logic             comparator_output, // comparator output, asynchronous
    input  wire logic             capt_irq_ack,   // capture interrupt executed
    input  wire logic             ovf_irq_ack,    // overflow interrupt executed
    output logic                  capt_irq,       // capture interrupt request
    output logic                  ovf_irq,        // overflow interrupt request
    output logic                  count_ceiling,  // counter at sequence ceiling
    output logic                  count_floor_zero, // counter at zero
    output logic [2:0]            clock_select,   // clock select field to prescaler
    output logic [3:0]            waveform_mode_field // mode to waveform logic
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]        ctrl_a_reg;
    logic [7:0]        ctrl_b_reg;
    logic [7:0]        cmp_ctrl_reg;
    logic [7:0]        mask_reg;
    logic [7:0]        hold_reg;
    logic [15:0]       timer_count_value_reg;
    logic [15:0]       capture_timestamp_reg;
    logic              capture_flag_reg;
    logic              overflow_flag_reg;
    tcc_pkg::tcc_dir_t dir_reg;
    logic [2:0]        sync_reg;
    logic [2:0]        cmp_sync_reg;
    logic              src_reg;
    logic [2:0]        filt_cnt_reg;
    logic              filt_reg;
    logic              edge_prev_reg;

    logic [15:0] top;
    logic        icr_top;
    logic        dual;
    logic        wr_cnt_lo;
    logic        rd_cnt_lo;
    logic        rd_cap_lo;
    logic        capt_event;
    logic        ovf_event;
    logic        clr_capt;
    logic        clr_ovf;
    logic        raw_in;
    logic        edge_in;
    logic        pin_stable;
    logic        cmp_stable;

    // decodes one access to a location
    function automatic logic hit(input logic strobe, input logic [3:0] a, input logic [3:0] want);
        hit = strobe && (a == want);
    endfunction

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    assign waveform_mode_field = {ctrl_b_reg[4:3], ctrl_a_reg[1:0]};
    assign clock_select        = ctrl_b_reg[2:0];
    assign icr_top = (waveform_mode_field == tcc_pkg::WGM_PWM_ICR)   ||
                     (waveform_mode_field == tcc_pkg::WGM_PWM_ICR_F) ||
                     (waveform_mode_field == tcc_pkg::WGM_CTC_ICR)   ||
                     (waveform_mode_field == tcc_pkg::WGM_FAST_ICR);
    assign dual = (waveform_mode_field == tcc_pkg::WGM_PC8)     ||
                  (waveform_mode_field == tcc_pkg::WGM_PC9)     ||
                  (waveform_mode_field == tcc_pkg::WGM_PC10)    ||
                  (waveform_mode_field == tcc_pkg::WGM_PWM_ICR) ||
                  (waveform_mode_field == tcc_pkg::WGM_PFC_OCR) ||
                  (waveform_mode_field == tcc_pkg::WGM_PWM_ICR_F) ||
                  (waveform_mode_field == tcc_pkg::WGM_PC_OCR);

    // ceiling value per mode
    always_comb
    begin
        case (waveform_mode_field)
            4'h1, 4'h5:  top = 16'h00FF;
            4'h2, 4'h6:  top = 16'h01FF;
            4'h3, 4'h7:  top = 16'h03FF;
            4'h4, 4'h9, 4'hB, 4'hF: top = ceiling_ocr;
            4'h8, 4'hA, 4'hC, 4'hE: top = capture_timestamp_reg;
            default:     top = tcc_pkg::COUNT_MAX;
        endcase
    end

    // ceiling and zero markers
    assign count_ceiling    = (timer_count_value_reg == top);
    assign count_floor_zero = (timer_count_value_reg == tcc_pkg::COUNT_ZERO);

    // ------------------------------------------------------------
    // access strobes
    // ------------------------------------------------------------
    assign wr_cnt_lo = hit(bus.wr, bus.addr, tcc_pkg::ADDR_COUNT_LO);
    assign rd_cnt_lo = hit(bus.rd, bus.addr, tcc_pkg::ADDR_COUNT_LO);
    assign rd_cap_lo = hit(bus.rd, bus.addr, tcc_pkg::ADDR_CAPT_LO);
    assign clr_capt  = (hit(bus.wr, bus.addr, tcc_pkg::ADDR_IRQ_FLAG) && bus.wdata[tcc_pkg::BIT_CAPT])
                       || capt_irq_ack;
    assign clr_ovf   = (hit(bus.wr, bus.addr, tcc_pkg::ADDR_IRQ_FLAG) && bus.wdata[tcc_pkg::BIT_OVF])
                       || ovf_irq_ack;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_a_reg   <= tcc_pkg::BYTE_ZERO;
            ctrl_b_reg   <= tcc_pkg::BYTE_ZERO;
            cmp_ctrl_reg <= tcc_pkg::BYTE_ZERO;
            mask_reg     <= tcc_pkg::BYTE_ZERO;
        end
        else if (bus.wr)
        begin
            if (bus.addr == tcc_pkg::ADDR_CTRL_A)   ctrl_a_reg   <= bus.wdata;
            if (bus.addr == tcc_pkg::ADDR_CTRL_B)   ctrl_b_reg   <= bus.wdata;
            if (bus.addr == tcc_pkg::ADDR_CMP_CTRL) cmp_ctrl_reg <= bus.wdata;
            if (bus.addr == tcc_pkg::ADDR_IRQ_MASK) mask_reg     <= bus.wdata;
        end
    end

    // shared high-byte holding register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            hold_reg <= tcc_pkg::BYTE_ZERO;
        else if (rd_cnt_lo)
            hold_reg <= timer_count_value_reg[15:8];
        else if (rd_cap_lo)
            hold_reg <= capture_timestamp_reg[15:8];
        else if (hit(bus.wr, bus.addr, tcc_pkg::ADDR_COUNT_HI) ||
                 hit(bus.wr, bus.addr, tcc_pkg::ADDR_CAPT_HI))
            hold_reg <= bus.wdata;
    end

    // ------------------------------------------------------------
    // counter unit
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timer_count_value_reg <= tcc_pkg::COUNT_ZERO;
            dir_reg               <= tcc_pkg::DIR_UP;
        end
        else if (wr_cnt_lo)
            timer_count_value_reg <= {hold_reg, bus.wdata};
        else if (timer_tick && clock_select != tcc_pkg::CS_STOPPED)
        begin
            if (dual)
            begin
                if (dir_reg == tcc_pkg::DIR_UP)
                begin
                    if (count_ceiling)
                    begin
                        dir_reg               <= tcc_pkg::DIR_DOWN;
                        timer_count_value_reg <= timer_count_value_reg - tcc_pkg::COUNT_ONE;
                    end
                    else
                        timer_count_value_reg <= timer_count_value_reg + tcc_pkg::COUNT_ONE;
                end
                else if (count_floor_zero)
                begin
                    dir_reg               <= tcc_pkg::DIR_UP;
                    timer_count_value_reg <= timer_count_value_reg + tcc_pkg::COUNT_ONE;
                end
                else
                    timer_count_value_reg <= timer_count_value_reg - tcc_pkg::COUNT_ONE;
            end
            else
            begin
                dir_reg <= tcc_pkg::DIR_UP;
                if (count_ceiling)
                    timer_count_value_reg <= tcc_pkg::COUNT_ZERO;
                else
                    timer_count_value_reg <= timer_count_value_reg + tcc_pkg::COUNT_ONE;
            end
        end
    end

    // overflow point: zero in dual slope, max in normal/ctc, ceiling otherwise
    always_comb
    begin
        ovf_event = 1'b0;
        if (timer_tick && clock_select != tcc_pkg::CS_STOPPED && !wr_cnt_lo)
        begin
            case (waveform_mode_field)
                4'h0, 4'h4, 4'hC: ovf_event = (timer_count_value_reg == tcc_pkg::COUNT_MAX);
                default:          ovf_event = dual ? count_floor_zero : count_ceiling;
            endcase
        end
    end

    // overflow flag, set wins over clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            overflow_flag_reg <= 1'b0;
        else if (ovf_event)
            overflow_flag_reg <= 1'b1;
        else if (clr_ovf)
            overflow_flag_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // capture input: three-stage sampling, filter, edge detector
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_reg     <= 3'h0;
            cmp_sync_reg <= 3'h0;
        end
        else
        begin
            sync_reg     <= {sync_reg[1:0], capture_input_pin};
            cmp_sync_reg <= {cmp_sync_reg[1:0], comparator_output};
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_stable <= 1'b0;
            cmp_stable <= 1'b0;
        end
        else
        begin
            if (sync_reg[1] == sync_reg[2])         pin_stable <= sync_reg[2];
            if (cmp_sync_reg[1] == cmp_sync_reg[2]) cmp_stable <= cmp_sync_reg[2];
        end
    end

    assign raw_in = cmp_ctrl_reg[tcc_pkg::BIT_CMP_SEL] ? cmp_stable : pin_stable;

    // noise filter: output follows after four equal samples
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            src_reg      <= 1'b0;
            filt_cnt_reg <= 3'h0;
            filt_reg     <= 1'b0;
        end
        else
        begin
            src_reg <= raw_in;
            if (src_reg != raw_in)
                filt_cnt_reg <= 3'h0;
            else if (filt_cnt_reg != tcc_pkg::FILT_LAST)
                filt_cnt_reg <= filt_cnt_reg + 3'h1;
            if (src_reg == raw_in && filt_cnt_reg == tcc_pkg::FILT_LAST - 3'h1)
                filt_reg <= raw_in;
        end
    end

    assign edge_in = ctrl_b_reg[tcc_pkg::BIT_FILT] ? filt_reg : raw_in;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            edge_prev_reg <= 1'b0;
        else
            edge_prev_reg <= edge_in;
    end

    // matching edge, disabled in capture-ceiling modes
    assign capt_event = !icr_top && (edge_in != edge_prev_reg) &&
                        (edge_in == ctrl_b_reg[tcc_pkg::BIT_EDGE]);

    // capture register: capture or ceiling write
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            capture_timestamp_reg <= tcc_pkg::COUNT_ZERO;
        else if (capt_event)
            capture_timestamp_reg <= timer_count_value_reg;
        else if (icr_top && hit(bus.wr, bus.addr, tcc_pkg::ADDR_CAPT_LO))
            capture_timestamp_reg <= {hold_reg, bus.wdata};
    end

    // capture flag, set wins over clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            capture_flag_reg <= 1'b0;
        else if (capt_event)
            capture_flag_reg <= 1'b1;
        else if (clr_capt)
            capture_flag_reg <= 1'b0;
    end

    assign capt_irq = capture_flag_reg && mask_reg[tcc_pkg::BIT_CAPT];
    assign ovf_irq  = overflow_flag_reg && mask_reg[tcc_pkg::BIT_OVF];

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata <= tcc_pkg::BYTE_ZERO;
        else if (bus.rd)
        begin
            case (bus.addr)
                tcc_pkg::ADDR_CTRL_A:   rdata <= ctrl_a_reg;
                tcc_pkg::ADDR_CTRL_B:   rdata <= ctrl_b_reg;
                tcc_pkg::ADDR_COUNT_LO: rdata <= timer_count_value_reg[7:0];
                tcc_pkg::ADDR_COUNT_HI: rdata <= hold_reg;
                tcc_pkg::ADDR_CAPT_LO:  rdata <= capture_timestamp_reg[7:0];
                tcc_pkg::ADDR_CAPT_HI:  rdata <= hold_reg;
                tcc_pkg::ADDR_IRQ_MASK: rdata <= mask_reg;
                tcc_pkg::ADDR_IRQ_FLAG: rdata <= {2'h0, capture_flag_reg, 4'h0, overflow_flag_reg};
                tcc_pkg::ADDR_CMP_CTRL: rdata <= cmp_ctrl_reg;
                default:                rdata <= tcc_pkg::BYTE_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_capt_copy;
        @(posedge clk) disable iff (!arst_n)
        capt_event |=> capture_timestamp_reg == $past(timer_count_value_reg) && capture_flag_reg;
    endproperty
    a_capt_copy: assert property (p_capt_copy) else $error("capture did not copy count");

    property p_write_wins;
        @(posedge clk) disable iff (!arst_n)
        wr_cnt_lo |=> timer_count_value_reg == {$past(hold_reg), $past(bus.wdata)};
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("counter write lost");

    property p_stopped;
        @(posedge clk) disable iff (!arst_n)
        (clock_select == tcc_pkg::CS_STOPPED && !wr_cnt_lo) |=> $stable(timer_count_value_reg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

    property p_hold_lo_read;
        @(posedge clk) disable iff (!arst_n)
        rd_cnt_lo |=> hold_reg == $past(timer_count_value_reg[15:8]);
    endproperty
    a_hold_lo_read: assert property (p_hold_lo_read) else $error("holding byte not loaded");

    property p_flag_clear;
        @(posedge clk) disable iff (!arst_n)
        (clr_capt && !capt_event) |=> !capture_flag_reg;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("capture flag not cleared");

    property p_no_capt_icr;
        @(posedge clk) disable iff (!arst_n)
        (icr_top && !hit(bus.wr, bus.addr, tcc_pkg::ADDR_CAPT_LO))
            |=> $stable(capture_timestamp_reg) && !$rose(capture_flag_reg);
    endproperty
    a_no_capt_icr: assert property (p_no_capt_icr) else $error("capture in ceiling mode");

    property p_count_step;
        @(posedge clk) disable iff (!arst_n)
        (timer_tick && clock_select != tcc_pkg::CS_STOPPED && !wr_cnt_lo && !dual && !count_ceiling)
            |=> timer_count_value_reg == $past(timer_count_value_reg) + tcc_pkg::COUNT_ONE;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step");

    property p_filter;
        @(posedge clk) disable iff (!arst_n)
        $changed(filt_reg) |-> $past(raw_in, 1) == filt_reg && $past(raw_in, 2) == filt_reg
                               && $past(raw_in, 3) == filt_reg;
    endproperty
    a_filter: assert property (p_filter) else $error("filter changed early");

endmodule // tcc_timer16

// *** verification/tb_top.sv ***
// self-checking bench for the 16-bit timer with capture
`timescale 1ns/1ps
module tb_top;
    logic              clk = 1'b0;
    logic              arst_n = 1'b0;
    tcc_pkg::tcc_bus_t bus;
    logic [7:0]        rdata, b;
    logic              tick = 1'b0, pin = 1'b0, cmp = 1'b0, c_ack = 1'b0, o_ack = 1'b0;
    logic              c_irq, o_irq, fz;
    logic [3:0]        wfm;
    logic [15:0]       w;
    int                err_count = 0;
    int                samples_checked = 0;
    always #50 clk = ~clk;
    tcc_timer16 DUT (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .timer_tick(tick),
        .ceiling_ocr(16'h00FF), .capture_input_pin(pin), .comparator_output(cmp), .capt_irq_ack(c_ack),
        .ovf_irq_ack(o_ack), .capt_irq(c_irq), .ovf_irq(o_irq), .count_ceiling(), .count_floor_zero(fz),
        .clock_select(), .waveform_mode_field(wfm));
    tcc_cpu_model cpu (.clk(clk), .bus(bus), .rdata(rdata));
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // timer tick pulses, one per two cycles
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
        end
    endtask
    task automatic conclude;
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #2000000;
        err_count++;
        conclude();
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        pulse(2);
        chk(fz, 1'b1);
        cpu.wr16(tcc_pkg::ADDR_COUNT_LO, 16'h01FF);
        cpu.rd16(tcc_pkg::ADDR_COUNT_LO, w);
        chk(w, 16'h01FF);
        cpu.wr8(tcc_pkg::ADDR_CTRL_B, 8'h41);
        pulse(3);
        cpu.rd16(tcc_pkg::ADDR_COUNT_LO, w);
        chk(w, 16'h0202);
        cpu.wr16(tcc_pkg::ADDR_COUNT_LO, tcc_pkg::COUNT_MAX);
        cpu.wr8(tcc_pkg::ADDR_IRQ_MASK, 8'h21);
        pulse(1);
        @(negedge clk) chk({fz, o_irq}, 2'b11);
        @(posedge clk) o_ack <= 1'b1;
        @(posedge clk) o_ack <= 1'b0;
        @(negedge clk) chk(o_irq, 1'b0);
        // low-byte write lands on the same edge as a tick
        cpu.wr8(tcc_pkg::ADDR_COUNT_HI, 8'h12);
        fork
            cpu.wr8(tcc_pkg::ADDR_COUNT_LO, 8'h34);
            pulse(1);
        join
        cpu.rd16(tcc_pkg::ADDR_COUNT_LO, w);
        chk(w, 16'h1234);
        cpu.wr8(tcc_pkg::ADDR_CTRL_B, 8'h40);
        @(posedge clk) pin <= 1'b1;
        repeat (12) @(posedge clk);
        chk(c_irq, 1'b1);
        cpu.rd16(tcc_pkg::ADDR_CAPT_LO, w);
        chk(w, 16'h1234);
        cpu.wr8(tcc_pkg::ADDR_IRQ_FLAG, 8'h20);
        cpu.rd8(tcc_pkg::ADDR_IRQ_FLAG, b);
        chk(b[5], 1'b0);
        // filter on: falling edge and a short glitch give nothing
        cpu.wr8(tcc_pkg::ADDR_CTRL_B, 8'hC0);
        cpu.wr16(tcc_pkg::ADDR_COUNT_LO, 16'h0055);
        pin <= 1'b0;
        repeat (16) @(posedge clk);
        pin <= 1'b1;
        repeat (3) @(posedge clk);
        pin <= 1'b0;
        repeat (16) @(posedge clk);
        chk(c_irq, 1'b0);
        pin <= 1'b1;
        repeat (16) @(posedge clk);
        cpu.rd16(tcc_pkg::ADDR_CAPT_LO, w);
        chk(w, 16'h0055);
        @(posedge clk) c_ack <= 1'b1;
        @(posedge clk) c_ack <= 1'b0;
        @(negedge clk) chk(c_irq, 1'b0);
        // comparator as source, flag cleared after the switch
        cpu.wr8(tcc_pkg::ADDR_CMP_CTRL, 8'h04);
        repeat (12) @(posedge clk);
        cpu.wr8(tcc_pkg::ADDR_IRQ_FLAG, 8'h20);
        cpu.wr16(tcc_pkg::ADDR_COUNT_LO, 16'h0777);
        cmp <= 1'b1;
        repeat (16) @(posedge clk);
        cpu.rd16(tcc_pkg::ADDR_CAPT_LO, w);
        chk(w, 16'h0777);
        cpu.wr16(tcc_pkg::ADDR_CAPT_LO, 16'h1111);
        cpu.rd16(tcc_pkg::ADDR_CAPT_LO, w);
        chk(w, 16'h0777);
        // mode set before the ceiling is written
        cpu.wr8(tcc_pkg::ADDR_CTRL_B, 8'hD8);
        @(negedge clk) chk(wfm, tcc_pkg::WGM_CTC_ICR);
        cpu.wr16(tcc_pkg::ADDR_CAPT_LO, 16'hABCD);
        cpu.wr8(tcc_pkg::ADDR_COUNT_LO, 8'hEF);
        cpu.wr8(tcc_pkg::ADDR_IRQ_FLAG, 8'h20);
        cmp <= 1'b0;
        repeat (16) @(posedge clk);
        cmp <= 1'b1;
        repeat (16) @(posedge clk);
        cpu.rd16(tcc_pkg::ADDR_CAPT_LO, w);
        chk(w, 16'hABCD);
        chk(c_irq, 1'b0);
        cpu.rd16(tcc_pkg::ADDR_COUNT_LO, w);
        chk(w, 16'hABEF);
        // compare-unit ceiling: wraps to zero after the ceiling
        cpu.wr8(tcc_pkg::ADDR_CTRL_B, 8'h49);
        cpu.wr16(tcc_pkg::ADDR_COUNT_LO, 16'h00FE);
        pulse(2);
        @(negedge clk) chk(fz, 1'b1);
        // dual slope: turns down at the ceiling, overflow on the tick that finds it at zero and turns it up
        cpu.wr8(tcc_pkg::ADDR_CTRL_A, 8'h01);
        cpu.wr8(tcc_pkg::ADDR_CTRL_B, 8'h41);
        cpu.wr16(tcc_pkg::ADDR_COUNT_LO, 16'h00FE);
        pulse(3);
        cpu.rd16(tcc_pkg::ADDR_COUNT_LO, w);
        chk(w, 16'h00FD);
        cpu.wr16(tcc_pkg::ADDR_COUNT_LO, 16'h0001);
        pulse(2);
        @(negedge clk) chk(o_irq, 1'b1);
        cpu.rd16(tcc_pkg::ADDR_COUNT_LO, w);
        chk(w, 16'h0001);
        cpu.rd8(4'h9, b);
        chk(b, 8'h00);
        conclude();
    end
endmodule // tb_top

// *** verification/tcc_cpu_model.sv ***
// processor core model driving the timer's byte bus
`timescale 1ns/1ps
module tcc_cpu_model (
    input  wire logic         clk,   // system clock
    output tcc_pkg::tcc_bus_t bus,   // access strobes
    input  wire logic [7:0]   rdata  // read data
);
    initial bus = '0;
    // one write, held up to the taking edge, then data no longer valid
    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) bus <= {2'b01, a, d};
        @(posedge clk) bus <= {2'b00, a, ~d};
    endtask
    // one read, answer taken once the registered data has landed
    task automatic rd8(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk) bus <= {2'b10, a, 8'h00};
        @(posedge clk) bus <= {2'b00, a, 8'hFF};
        @(negedge clk) d = rdata;
    endtask
    // high location first, low write moves all sixteen bits
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr8(a + 4'h1, v[15:8]);
        wr8(a, v[7:0]);
    endtask
    // low byte first, high byte comes back from the holding register
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        rd8(a, v[7:0]);
        rd8(a + 4'h1, v[15:8]);
    endtask
endmodule // tcc_cpu_model
